//--- msj_consts.svh
`ifndef MSJ_CONSTS_SVH
`define MSJ_CONSTS_SVH
// How it works
// - terminals coded 02..05 are binary weights 1..4 selecting speed 0..15.
// - binary speeds 1..15 take their frequency from the fifteen stored step references.
// - source setting 02 makes the stored operator frequency speed 0 in both modes.
// - source setting 01 makes the analog input speed 0.
// - a binary pattern is accepted only after staying unchanged for the settle time.
// - terminals coded 32..38 are seven select bits choosing speed 0..7.
// - bit-mode speeds 1..7 use stored step references 1..7, one per bit.
// - lowest active select bit wins; no active bit gives speed 0.
// - a terminal coded 06 is the jog input.
// - with jog enabled, jogging starts when a run command arrives.
// - jog frequency is applied as a step, bypassing the ramp.
// - jog frequency accepts 0.00 or start frequency..9.99 Hz; resets to 6.00 Hz.
// - stop codes 00..02 stop by free-run/decel/DC brake; no jog while running.
// - stop codes 03..05 stop likewise and allow jog while running; default 04.
// - mode setting 00 selects binary, 01 bit operation; default 00.
// - jog must come before run; with codes 00..02 run first means no jog.
// - with codes 03..05, jog released before run gives a free-run stop.

// register byte offsets
`define MSJ_OFF_MODE     8'h00
`define MSJ_OFF_SRC      8'h04
`define MSJ_OFF_OPFREQ   8'h08
`define MSJ_OFF_SETTLE   8'h0C
`define MSJ_OFF_JOGF     8'h10
`define MSJ_OFF_JSTOP    8'h14
`define MSJ_OFF_DCBRAKE  8'h18
`define MSJ_OFF_STARTF   8'h1C
`define MSJ_OFF_STATUS   8'h20
`define MSJ_OFF_FSEL     8'h40
`define MSJ_OFF_STEP     8'h80
// terminal function codes
`define MSJ_FN_BIN1      6'h02
`define MSJ_FN_JOG       6'h06
`define MSJ_FN_BIT1      6'h20
// field values and reset values
`define MSJ_SRC_ANALOG   2'h1
`define MSJ_SRC_OPER     2'h2
`define MSJ_MODE_RST     1'h0
`define MSJ_SRC_RST      2'h2
`define MSJ_JOGF_RST     16'h0258
`define MSJ_JOGF_MAX     16'h03E7
`define MSJ_JSTOP_RST    3'h4
`define MSJ_JSTOP_ENRUN  3'h3
`define MSJ_JSTOP_MAX    3'h5
`define MSJ_SETTLE_RST   16'h0005
// settle time unit is 1 ms
`define MSJ_CLK_MHZ      125
`define MSJ_SETTLE_UNIT_US 1000
`define MSJ_TICK_CYC     (`MSJ_CLK_MHZ * `MSJ_SETTLE_UNIT_US)
`endif

//--- msj_pkg.sv
package msj_pkg;
    typedef enum logic [1:0] {ST_STOP, ST_RUN, ST_JOG, ST_COAST} msj_state_t;
    typedef enum logic [1:0] {STOP_FREE, STOP_DECEL, STOP_DC} msj_stop_t;
endpackage : msj_pkg

//--- msj_speed_select.sv
`timescale 1ns/1ps
`include "msj_consts.svh"
module msj_speed_select
    import msj_pkg::*;
#(
    parameter int NTERM    = 8,
    parameter int TICK_CYC = `MSJ_TICK_CYC
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // terminal pins
    input  wire logic [NTERM-1:0] term_in,
    input  wire logic        forward_run_input,
    input  wire logic        reverse_run_input,
    // analog frequency from converter logic on core_clk
    input  wire logic [15:0] analog_freq,
    // drive command outputs
    output logic [15:0]      freq_ref,
    output logic             ramp_bypass,
    output logic             drive_run,
    output logic             jog_active,
    output logic [1:0]       stop_method,
    output logic [1:0]       dc_brake_mode,
    output logic [3:0]       speed_index
);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // ==========================================================
    // pin synchronisers
    logic [NTERM+1:0] sync1_r;
    logic [NTERM+1:0] sync2_r;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {reverse_run_input, forward_run_input, term_in};
            sync2_r <= sync1_r;
        end
    end
    wire [NTERM-1:0] term_s = sync2_r[NTERM-1:0];
    wire             run_s  = sync2_r[NTERM] | sync2_r[NTERM+1];

    // ==========================================================
    // registers
    logic                  mode_r;
    logic [1:0]            src_r;
    logic [15:0]           opfreq_r;
    logic [15:0]           settle_r;
    logic [15:0]           jogf_r;
    logic [2:0]            jstop_r;
    logic [1:0]            dcb_r;
    logic [15:0]           startf_r;
    logic [5:0]            fsel_r [NTERM];
    logic [15:0]           step_r [16];

    // ==========================================================
    // ahb-lite slave: writes zero-wait, reads one wait state
    logic        wr_pend_r;
    logic        rd_pend_r;
    logic [7:0]  addr_r;
    wire         take   = hsel & hready & htrans[1];
    wire [7:0]   a      = addr_r;
    wire         hit_fs = (a[7:5] == 3'h2);
    wire         hit_st = (a[7:6] == 2'h2);
    wire [2:0]   fs_i   = a[4:2];
    wire [3:0]   st_i   = a[5:2];
    wire [15:0]  wd16   = hwdata[15:0];
    // jog frequency writes outside the legal range are dropped
    wire         jogf_ok = (wd16 == 16'h0000) ||
                           (wd16 >= startf_r && wd16 <= `MSJ_JOGF_MAX);
    wire         wr     = wr_pend_r;
    logic [31:0] rd_mux;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else begin
            wr_pend_r <= take & hwrite;
            rd_pend_r <= take & ~hwrite;
            if (take) begin
                addr_r <= haddr[7:0];
            end
            hreadyout <= ~(take & ~hwrite);
            if (rd_pend_r) begin
                hrdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mode_r   <= `MSJ_MODE_RST;
            src_r    <= `MSJ_SRC_RST;
            opfreq_r <= 16'h0000;
            settle_r <= `MSJ_SETTLE_RST;
            jogf_r   <= `MSJ_JOGF_RST;
            jstop_r  <= `MSJ_JSTOP_RST;
            dcb_r    <= 2'h0;
            startf_r <= 16'h0000;
            for (int i = 0; i < NTERM; i++) fsel_r[i] <= 6'h00;
            for (int i = 0; i < 16; i++) step_r[i] <= 16'h0000;
        end else if (wr) begin
            if (a == `MSJ_OFF_MODE) mode_r <= hwdata[0];
            if (a == `MSJ_OFF_SRC) src_r <= hwdata[1:0];
            if (a == `MSJ_OFF_OPFREQ) opfreq_r <= wd16;
            if (a == `MSJ_OFF_SETTLE) settle_r <= wd16;
            if (a == `MSJ_OFF_JOGF && jogf_ok) jogf_r <= wd16;
            if (a == `MSJ_OFF_JSTOP && hwdata[2:0] <= `MSJ_JSTOP_MAX) jstop_r <= hwdata[2:0];
            // software owns the brake pairing for stop codes 02 and 05
            if (a == `MSJ_OFF_DCBRAKE) dcb_r <= hwdata[1:0];
            if (a == `MSJ_OFF_STARTF) startf_r <= wd16;
            if (hit_fs && a[1:0] == 2'b00) fsel_r[fs_i] <= hwdata[5:0];
            if (hit_st && a[1:0] == 2'b00 && st_i != 4'h0) step_r[st_i] <= wd16;
        end
    end

    // ==========================================================
    // terminal decode
    wire [4*NTERM-1:0] bin_hit;
    wire [7*NTERM-1:0] bit_hit;
    wire [NTERM-1:0]   jog_hit;
    logic [3:0]        bin_pat;
    logic [6:0]        bit_pat;
    genvar gi;
    genvar gk;
    generate
        for (gi = 0; gi < NTERM; gi++) begin : g_term
            for (gk = 0; gk < 4; gk++) begin : g_bin
                assign bin_hit[gk*NTERM+gi] = term_s[gi] &
                    (fsel_r[gi] == `MSJ_FN_BIN1 + 6'(gk));
            end
            for (gk = 0; gk < 7; gk++) begin : g_bit
                assign bit_hit[gk*NTERM+gi] = term_s[gi] &
                    (fsel_r[gi] == `MSJ_FN_BIT1 + 6'(gk));
            end
            assign jog_hit[gi] = term_s[gi] & (fsel_r[gi] == `MSJ_FN_JOG);
        end
        for (gk = 0; gk < 4; gk++) begin : g_binor
            assign bin_pat[gk] = |bin_hit[gk*NTERM +: NTERM];
        end
        for (gk = 0; gk < 7; gk++) begin : g_bitor
            assign bit_pat[gk] = |bit_hit[gk*NTERM +: NTERM];
        end
    endgenerate
    wire jog_in = |jog_hit;

    // ==========================================================
    // binary settle timer
    // the ms tick restarts with the pattern, so the wait is exact to one cycle
    logic [16:0] tick_r;
    logic [15:0] cnt_r;
    logic [3:0]  pat_prev_r;
    logic [3:0]  det_pat_r;
    logic        det_valid_r;
    logic        pend_r;
    wire         changed = (bin_pat != pat_prev_r);
    wire         tick    = (tick_r == 17'(TICK_CYC - 1));
    wire         settled = pend_r & ~changed & (cnt_r >= settle_r);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tick_r      <= 17'h0_0000;
            cnt_r       <= 16'h0000;
            pat_prev_r  <= 4'h0;
            det_pat_r   <= 4'h0;
            det_valid_r <= 1'b0;
            pend_r      <= 1'b1;
        end else begin
            pat_prev_r <= bin_pat;
            if (changed) begin
                tick_r <= 17'h0_0000;
                cnt_r  <= 16'h0000;
                pend_r <= 1'b1;
            end else if (settled) begin
                det_pat_r   <= pat_prev_r;
                det_valid_r <= 1'b1;
                pend_r      <= 1'b0;
            end else if (pend_r) begin
                tick_r <= tick ? 17'h0_0000 : tick_r + 17'h0_0001;
                if (tick) cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    // ==========================================================
    // speed selection
    wire [3:0] bit_idx = bit_pat[0] ? 4'h1 : bit_pat[1] ? 4'h2 :
                         bit_pat[2] ? 4'h3 : bit_pat[3] ? 4'h4 :
                         bit_pat[4] ? 4'h5 : bit_pat[5] ? 4'h6 :
                         bit_pat[6] ? 4'h7 : 4'h0;
    wire [3:0] bin_idx = det_valid_r ? det_pat_r : 4'h0;
    wire [3:0] idx_sel = mode_r ? bit_idx : bin_idx;
    wire [15:0] ref0   = (src_r == `MSJ_SRC_OPER)   ? opfreq_r :
                         (src_r == `MSJ_SRC_ANALOG) ? analog_freq :
                         16'h0000;
    // step_r serves both modes; bit mode only reaches entries 1..7
    wire [15:0] step_f = (idx_sel == 4'h0) ? ref0 : step_r[idx_sel];

    // ==========================================================
    // run and jog sequencing
    msj_state_t state_r;
    msj_state_t state_nxt;
    wire        en_run  = (jstop_r >= `MSJ_JSTOP_ENRUN);
    wire [1:0]  jog_stp = en_run ? 2'(jstop_r - `MSJ_JSTOP_ENRUN) : jstop_r[1:0];

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_STOP:  if (run_s) state_nxt = jog_in ? ST_JOG : ST_RUN;
            ST_RUN: begin
                if (!run_s) state_nxt = ST_STOP;
                else if (jog_in && en_run) state_nxt = ST_JOG;
            end
            ST_JOG: begin
                if (!run_s) state_nxt = ST_STOP;
                else if (!jog_in) state_nxt = en_run ? ST_COAST : ST_RUN;
            end
            ST_COAST: if (!run_s) state_nxt = ST_STOP;
            default:  state_nxt = ST_STOP;
        endcase
    end

    wire        jog_nxt  = (state_nxt == ST_JOG);
    wire        run_nxt  = (state_nxt == ST_RUN) | jog_nxt;
    wire [15:0] freq_nxt = jog_nxt ? jogf_r : run_nxt ? step_f : 16'h0000;
    wire [1:0]  stop_nxt = (state_nxt == ST_COAST) ? 2'(STOP_FREE) :
                           (state_r == ST_JOG) ? jog_stp :
                           (state_r == ST_RUN) ? 2'(STOP_DECEL) : stop_method;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r       <= ST_STOP;
            freq_ref      <= 16'h0000;
            ramp_bypass   <= 1'b0;
            drive_run     <= 1'b0;
            jog_active    <= 1'b0;
            stop_method   <= 2'(STOP_DECEL);
            dc_brake_mode <= 2'h0;
            speed_index   <= 4'h0;
        end else begin
            state_r       <= state_nxt;
            freq_ref      <= freq_nxt;
            ramp_bypass   <= jog_nxt;
            drive_run     <= run_nxt;
            jog_active    <= jog_nxt;
            stop_method   <= stop_nxt;
            dc_brake_mode <= dcb_r;
            speed_index   <= idx_sel;
        end
    end

    // ==========================================================
    // read mux
    wire [31:0] status_w = {16'h0000, det_valid_r, jog_in, run_s, state_r,
                            stop_method, det_pat_r, speed_index, 1'b0};
    assign rd_mux =
        (a == `MSJ_OFF_MODE)    ? {31'h0, mode_r} :
        (a == `MSJ_OFF_SRC)     ? {30'h0, src_r} :
        (a == `MSJ_OFF_OPFREQ)  ? {16'h0, opfreq_r} :
        (a == `MSJ_OFF_SETTLE)  ? {16'h0, settle_r} :
        (a == `MSJ_OFF_JOGF)    ? {16'h0, jogf_r} :
        (a == `MSJ_OFF_JSTOP)   ? {29'h0, jstop_r} :
        (a == `MSJ_OFF_DCBRAKE) ? {30'h0, dcb_r} :
        (a == `MSJ_OFF_STARTF)  ? {16'h0, startf_r} :
        (a == `MSJ_OFF_STATUS)  ? status_w :
        (hit_fs && a[1:0] == 2'b00) ? {26'h0, fsel_r[fs_i]} :
        (hit_st && a[1:0] == 2'b00) ? {16'h0, step_r[st_i]} :
        32'h0000_0000;

    // ==========================================================
    // checks
    sequence s_jog_req;
        state_r == ST_STOP && run_s && jog_in;
    endsequence
    sequence s_jog_on;
        jog_active && ramp_bypass && freq_ref == $past(jogf_r);
    endsequence

    chk_idx_held_zero: assert property (
        (!mode_r && !det_valid_r) |=> speed_index == 4'h0)
        else $error("speed index moved before a pattern was determined");
    chk_settle_latch: assert property (
        settled |=> det_valid_r && det_pat_r == $past(pat_prev_r))
        else $error("settled pattern not latched");
    chk_timer_restart: assert property (
        changed |=> cnt_r == 16'h0000 && pend_r && det_pat_r == $past(det_pat_r))
        else $error("settle timer not restarted on change");
    chk_bit_lowest: assert property (
        (mode_r && bit_pat[0]) |=> speed_index == 4'h1)
        else $error("lowest select bit lost priority");
    chk_bit_none: assert property (
        (mode_r && bit_pat == 7'h00) |=> speed_index == 4'h0)
        else $error("no select bit but speed not zero");
    chk_jog_start: assert property (
        s_jog_req |=> s_jog_on)
        else $error("jog did not start as a step");
    chk_no_jog_run: assert property (
        (state_r == ST_RUN && !en_run) |=> state_r != ST_JOG)
        else $error("jog entered while running with disabled code");
    chk_jog_rel_free: assert property (
        (state_r == ST_JOG && run_s && !jog_in && en_run) |=>
            state_r == ST_COAST && stop_method == 2'(STOP_FREE) && !drive_run)
        else $error("jog release did not free-run");
    chk_jogf_range: assert property (
        jogf_r == 16'h0000 || jogf_r <= `MSJ_JOGF_MAX)
        else $error("jog frequency out of range");
    chk_ref0_oper: assert property (
        (run_nxt && !jog_nxt && idx_sel == 4'h0 && src_r == `MSJ_SRC_OPER)
            |=> freq_ref == $past(opfreq_r))
        else $error("speed zero not from operator value");
    // step entry and stop codes are watched apart from the state logic that uses them
    chk_ref0_analog: assert property (
        (run_nxt && !jog_nxt && idx_sel == 4'h0 && src_r == `MSJ_SRC_ANALOG) |=> freq_ref == $past(analog_freq))
        else $error("speed zero not from analog input");
    chk_jog_step: assert property (
        jog_nxt |=> jog_active && ramp_bypass && freq_ref == $past(jogf_r))
        else $error("jog frequency not applied as a step");
    chk_jog_stop_code: assert property (
        (state_r == ST_JOG && !run_s && !en_run) |=> !drive_run && stop_method == $past(jstop_r[1:0]))
        else $error("jog stop did not follow the stop code");
    chk_run_first: assert property (
        (state_r == ST_STOP && run_s && !jog_in) |=> state_r == ST_RUN && !jog_active)
        else $error("run without jog input did not give a plain run");

endmodule : msj_speed_select

//--- msj_ctrl_model.sv
`timescale 1ns/1ps
module msj_ctrl_model (
    // clock
    input  wire logic  core_clk,
    // terminal pins towards the block
    output logic [7:0] term_in,
    output logic       forward_run_input,
    output logic       reverse_run_input
);
    // ==========================================================
    // pin driver
    initial begin
        term_in           = 8'h00;
        forward_run_input = 1'b0;
        reverse_run_input = 1'b0;
    end

    // pins are plain levels, changed just after an edge like a relay output card
    task automatic drive(input logic [7:0] p, input logic f, input logic r);
        @(posedge core_clk);
        term_in           <= p;
        forward_run_input <= f;
        reverse_run_input <= r;
    endtask : drive

    // ==========================================================
    // jog request: jog terminal first, run some cycles later
    task automatic jog_run(input logic [7:0] p, input logic f, input logic r);
        drive(p, 1'b0, 1'b0);
        repeat (3) @(posedge core_clk);
        drive(p, f, r);
    endtask : jog_run
endmodule : msj_ctrl_model

//--- multistep_speed_jog_select_tb.sv
`timescale 1ns/1ps
`include "msj_consts.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t got=%h exp=%h", $time, g, e); end end
module multistep_speed_jog_select_tb;
    import msj_pkg::*;
    // short tick keeps the default 5-tick settle time at 20 cycles
    localparam int TICK = 4;
    typedef struct { logic md; logic [7:0] pat; logic [3:0] idx; } msj_row_t;

    logic        core_clk    = 1'b0;
    logic        reset       = 1'b1;
    logic        hsel        = 1'b0;
    logic [31:0] haddr       = 32'h0000_0000;
    logic [1:0]  htrans      = 2'h0;
    logic        hwrite      = 1'b0;
    logic [31:0] hwdata      = 32'h0000_0000;
    logic [15:0] analog_freq = 16'h0000;
    logic        hreadyout, hresp, fwd, rev, ramp_bypass, drive_run, jog_active, md;
    logic [31:0] hrdata, rd;
    logic [7:0]  term_in;
    logic [15:0] freq_ref;
    logic [1:0]  stop_method, dc_brake_mode;
    logic [3:0]  speed_index;
    int          n_errors = 0;
    int          checked  = 0;
    int          n;
    msj_row_t    rows[$];

    always #4 core_clk = ~core_clk;

    msj_speed_select #(.NTERM(8), .TICK_CYC(TICK)) uut (
        .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .term_in(term_in), .forward_run_input(fwd), .reverse_run_input(rev),
        .analog_freq(analog_freq), .freq_ref(freq_ref), .ramp_bypass(ramp_bypass), .drive_run(drive_run),
        .jog_active(jog_active), .stop_method(stop_method), .dc_brake_mode(dc_brake_mode),
        .speed_index(speed_index));

    msj_ctrl_model ctrl (.core_clk(core_clk), .term_in(term_in), .forward_run_input(fwd),
        .reverse_run_input(rev));

    // ==========================================================
    // report
    task automatic finish_test;
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // ==========================================================
    // ahb-lite master; hready looked at just before the edge that samples it
    task automatic wait_rdy;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            finish_test();
        end
        rd = hrdata;
        @(posedge core_clk);
    endtask : wait_rdy

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h00_0000, a};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
    endtask : rdchk

    // binary: weights on terminals 0..3; bit: selects on 0..6, jog on 7
    task automatic cfg_mode(input logic m);
        wr(`MSJ_OFF_MODE, {31'h0, m});
        for (int i = 0; i < 8; i++)
            wr(`MSJ_OFF_FSEL + 8'(4 * i), m ? ((i == 7) ? 32'(`MSJ_FN_JOG) : 32'(`MSJ_FN_BIT1) + i) : ((i < 4) ? 32'(`MSJ_FN_BIN1) + i : 32'h0));
        md = m;
    endtask : cfg_mode

    // ==========================================================
    // main sequence
    initial begin
        for (int p = 0; p < 16; p++) rows.push_back('{1'b0, 8'(p), 4'(p)});
        rows.push_back('{1'b1, 8'h00, 4'h0});
        rows.push_back('{1'b1, 8'h01, 4'h1});
        rows.push_back('{1'b1, 8'h7E, 4'h2});
        rows.push_back('{1'b1, 8'h7C, 4'h3});
        rows.push_back('{1'b1, 8'h38, 4'h4});
        rows.push_back('{1'b1, 8'h30, 4'h5});
        rows.push_back('{1'b1, 8'h20, 4'h6});
        rows.push_back('{1'b1, 8'h40, 4'h7});
        rows.push_back('{1'b1, 8'h55, 4'h1});
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        `CHK(speed_index, 4'h0)
        `CHK(stop_method, 2'h1)
        rdchk(`MSJ_OFF_MODE, 32'h0000_0000);
        rdchk(`MSJ_OFF_SRC, 32'h0000_0002);
        rdchk(`MSJ_OFF_JOGF, 32'h0000_0258);
        rdchk(`MSJ_OFF_JSTOP, 32'h0000_0004);
        wr(`MSJ_OFF_JOGF, 32'h0000_03E8);
        rdchk(`MSJ_OFF_JOGF, 32'h0000_0258);
        wr(`MSJ_OFF_STARTF, 32'h0000_0050);
        wr(`MSJ_OFF_JOGF, 32'h0000_0040);
        rdchk(`MSJ_OFF_JOGF, 32'h0000_0258);
        wr(`MSJ_OFF_JOGF, 32'h0000_0000);
        rdchk(`MSJ_OFF_JOGF, 32'h0000_0000);
        wr(`MSJ_OFF_JOGF, 32'h0000_03E7);
        rdchk(`MSJ_OFF_JOGF, 32'h0000_03E7);
        wr(`MSJ_OFF_JSTOP, 32'h0000_0006);
        rdchk(`MSJ_OFF_JSTOP, 32'h0000_0004);
        wr(`MSJ_OFF_STARTF, 32'h0000_0000);
        wr(`MSJ_OFF_OPFREQ, 32'h0000_1234);
        for (int k = 0; k < 16; k++) wr(`MSJ_OFF_STEP + 8'(4 * k), 32'h0000_0100 + k);
        rdchk(`MSJ_OFF_STEP, 32'h0000_0000);
        wr(8'h3C, 32'h0000_00AA);
        rdchk(8'h3C, 32'h0000_0000);
        wr(`MSJ_OFF_DCBRAKE, 32'h0000_0002);
        repeat (2) @(posedge core_clk);
        `CHK(dc_brake_mode, 2'h2)
        cfg_mode(1'b0);
        // a pattern younger than the settle time must not show
        ctrl.drive(8'h0F, 1'b1, 1'b0);
        repeat (10) @(posedge core_clk);
        `CHK(speed_index, 4'h0)
        repeat (40) @(posedge core_clk);
        `CHK(speed_index, 4'hF)
        for (int g = 0; g < 4; g++) begin
            ctrl.drive(g[0] ? 8'h05 : 8'h03, 1'b1, 1'b0);
            repeat (12) @(posedge core_clk);
        end
        `CHK(speed_index, 4'hF)
        repeat (40) @(posedge core_clk);
        `CHK(speed_index, 4'h5)
        wr(`MSJ_OFF_SRC, 32'h0000_0001);
        analog_freq <= 16'h0777;
        ctrl.drive(8'h00, 1'b1, 1'b0);
        repeat (40) @(posedge core_clk);
        `CHK(freq_ref, 16'h0777)
        wr(`MSJ_OFF_SRC, 32'h0000_0002);
        foreach (rows[i]) begin
            if (rows[i].md !== md) cfg_mode(rows[i].md);
            ctrl.drive(rows[i].pat, 1'b1, 1'b0);
            repeat (40) @(posedge core_clk);
            `CHK(speed_index, rows[i].idx)
            `CHK(freq_ref, (rows[i].idx == 4'h0) ? 16'h1234 : 16'h0100 + {12'h000, rows[i].idx})
        end
        ctrl.drive(8'h00, 1'b0, 1'b0);
        wr(`MSJ_OFF_JOGF, 32'h0000_0100);
        // every stop code, both run directions
        for (int c = 0; c < 6; c++) begin
            wr(`MSJ_OFF_JSTOP, 32'(c));
            ctrl.jog_run(8'h80, ~c[0], c[0]);
            for (n = 0; n < 20 && jog_active !== 1'b1; n++) @(negedge core_clk);
            `CHK(jog_active, 1'b1)
            `CHK(freq_ref, 16'h0100)
            `CHK({drive_run, ramp_bypass}, 2'b11)
            ctrl.drive(8'h80, 1'b0, 1'b0);
            repeat (6) @(posedge core_clk);
            `CHK({drive_run, jog_active, freq_ref}, 18'h0_0000)
            `CHK(stop_method, 2'(c % 3))
            ctrl.drive(8'h00, 1'b1, 1'b0);
            repeat (6) @(posedge core_clk);
            ctrl.drive(8'h80, 1'b1, 1'b0);
            repeat (6) @(posedge core_clk);
            `CHK(jog_active, (c >= 3))
            ctrl.drive(8'h00, 1'b1, 1'b0);
            repeat (6) @(posedge core_clk);
            `CHK(drive_run, (c < 3))
            if (c >= 3) `CHK(stop_method, 2'h0)
            ctrl.drive(8'h00, 1'b0, 1'b0);
            repeat (6) @(posedge core_clk);
        end
        // second reset in the middle of a jog
        ctrl.jog_run(8'h80, 1'b1, 1'b0);
        repeat (6) @(posedge core_clk);
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CHK({drive_run, stop_method, speed_index}, 7'h10)
        reset <= 1'b0;
        @(posedge core_clk);
        rdchk(`MSJ_OFF_JOGF, 32'h0000_0258);
        // run held through reset: plain run, decel, pattern zero determined
        repeat (40) @(posedge core_clk);
        rdchk(`MSJ_OFF_STATUS, 32'h0000_AA00);
        `CHK(hresp, 1'b0)
        finish_test();
    end
endmodule : multistep_speed_jog_select_tb
